// >>> rtl/spc_core.sv
/*
 * Eight-bit synchronous serial port, master or slave, with status,
 * control and data buffer registers on a plain strobe port.
 * Assumes pins are asynchronous to clock_in and are synchronised here;
 * the pad logic resolves the wires from the enables.
 */
// The plain strobed port and the placing of the registers were left to the implementer.
// Functional notes
// - Eight bits shifted out and in together
// - Most significant bit travels first
// - Full byte loads buffer, flags full, done
// - Buffer write while busy dropped, collision set
// - Collision flag sticks until software clears
// - Buffer full set on load, cleared by read
// - Slave overrun sets overflow, drops new byte
// - Master never sets overflow
// - Master buffer write starts a transfer
// - Buffer write loads buffer and shifter
// - Mode field picks role and clock
// - Enable bit claims pins, clear releases
// - Polarity bit sets serial clock idle level
// - Edge bit picks output change transition
// - Sample bit picks middle or end sampling in master
// - Stop bit cleared while port disabled
// - Status upper two bits writable only
// - Shifter reachable only through buffer
// - Master drives clock, slave receives it
// - Select high releases data, clears count
// - Reset disables port, abandons transfer
module spc_core (
   input  wire logic                        clock_in,     // System clock
   input  wire logic                        reset_n_in,   // Async, low
   input  wire logic [spc_pkg::ADDR_W-1:0]  addr_in,      // Register
   input  wire logic [spc_pkg::DATA_W-1:0]  wdata_in,     // Write data
   input  wire logic                        write_in,     // Write strobe
   input  wire logic                        read_in,      // Read strobe
   output logic      [spc_pkg::DATA_W-1:0]  rdata_out,    // Read data
   input  wire logic                        timer_two_in, // Timer pulse
   input  wire logic                        sck_in,       // Clock pin in
   output logic                             sck_out,      // Clock pin out
   output logic                             sck_oe_out,   // Clock drive
   input  wire logic                        sdi_in,       // Data in pin
   output logic                             sdo_out,      // Data out pin
   output logic                             sdo_oe_out,   // Data drive
   input  wire logic                        select_n_in,  // Select pin
   output logic                             transfer_done_out // Done
);
   import spc_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   spc_state_e state;
   logic       sample_phase, clock_edge, buffer_full;
   logic       write_collision, receive_overflow;
   logic       port_enable, clock_polarity;
   logic [3:0] port_mode_select;
   logic [7:0] transfer_buffer;
   logic [7:0] tx_shift, rx_shift;  // Together the transfer shifter
   logic [3:0] bit_cnt;
   logic [4:0] half;
   logic       sck_meta, sck_sync, sck_prev;
   logic       sdi_meta, sdi_sync;
   logic       sel_meta, sel_sync;

   spc_rate_if rate_if ();

   spc_rate_gen u_rate_gen (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .rate_port  (rate_if)
   );

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic wr_status, wr_control, wr_buffer, rd_buffer;
   logic is_master, is_slave, spi_on, sel_reset, busy;
   logic tick, m_lead, m_trail, s_lead, s_trail;
   logic samp, shift, done, keep_full, accept;
   logic [4:0] last_half;
   logic [7:0] rx_in, done_byte;

   assign wr_status  = write_in && (addr_in == OFS_STATUS);
   assign wr_control = write_in && (addr_in == OFS_CONTROL);
   assign wr_buffer  = write_in && (addr_in == OFS_BUFFER);
   assign rd_buffer  = read_in  && (addr_in == OFS_BUFFER);

   assign is_master = spc_is_master(port_mode_select);
   assign is_slave  = spc_is_slave(port_mode_select);
   assign spi_on    = port_enable && (is_master || is_slave);
   assign sel_reset = (port_mode_select == MODE_SLAVE_SELECT)
                      && sel_sync;
   assign busy      = (state == SPC_MASTER_RUN)
                      || (state == SPC_SLAVE_SHIFT);

   assign rate_if.rate_sel    = port_mode_select[1:0];
   assign rate_if.run         = (state == SPC_MASTER_RUN);
   assign rate_if.timer_pulse = timer_two_in;
   assign tick                = rate_if.tick && rate_if.run;

   // Master events fall on divider ticks; slave events on pin edges
   assign m_lead  = tick && !half[0] && (half != HALF_LAST_LATE);
   assign m_trail = tick && half[0];
   assign s_lead  = (sck_sync != sck_prev) && (sck_prev == clock_polarity);
   assign s_trail = (sck_sync != sck_prev) && (sck_prev != clock_polarity);
   // Late sampling with early output needs one extra half period
   assign last_half = (!clock_edge && sample_phase) ? HALF_LAST_LATE
                                                    : HALF_LAST;

   always_comb begin
      samp  = 1'b0;
      shift = 1'b0;
      done  = 1'b0;
      if (state == SPC_MASTER_RUN) begin
         if (sample_phase)
            samp = clock_edge ? m_trail : (tick && !half[0] && half != 5'h00);
         else
            samp = clock_edge ? m_lead : m_trail;
         shift = clock_edge ? (m_trail && half != HALF_LAST)
                            : (m_lead && half != 5'h00);
         done  = tick && (half == last_half);
      end else if (state == SPC_SLAVE_SHIFT
                   || state == SPC_SLAVE_WAIT) begin
         // Slave always samples mid bit; sample bit held low by software
         samp  = (clock_edge ? s_lead : s_trail) && !sel_reset;
         shift = (clock_edge ? s_trail : s_lead) && !sel_reset
                 && (bit_cnt != 4'h0);
         done  = samp && (bit_cnt == BITS_PER_WORD - 4'h1);
      end
   end

   assign rx_in     = {rx_shift[6:0], sdi_sync};
   assign done_byte = samp ? rx_in : rx_shift;
   assign keep_full = buffer_full && !rd_buffer;
   assign accept    = wr_buffer && !busy;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sck_meta <= 1'b0;
         sck_sync <= 1'b0;
         sck_prev <= 1'b0;
         sdi_meta <= 1'b0;
         sdi_sync <= 1'b0;
         sel_meta <= 1'b1;
         sel_sync <= 1'b1;
      end else begin
         sck_meta <= sck_in;
         sck_sync <= sck_meta;
         sck_prev <= sck_sync;
         sdi_meta <= sdi_in;
         sdi_sync <= sdi_meta;
         sel_meta <= select_n_in;
         sel_sync <= sel_meta;
      end
   end

   // ----------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state   <= SPC_IDLE;
         bit_cnt <= 4'h0;
         half    <= 5'h00;
      end else if (!spi_on) begin
         state   <= SPC_IDLE;
         bit_cnt <= 4'h0;
         half    <= 5'h00;
      end else begin
         unique case (state)
            SPC_IDLE: begin
               if (is_slave)
                  state <= SPC_SLAVE_WAIT;
               else if (accept)
                  state <= SPC_MASTER_RUN;
               bit_cnt <= 4'h0;
               half    <= 5'h00;
            end
            SPC_MASTER_RUN: begin
               if (done || !is_master)
                  state <= SPC_IDLE;
               if (done)
                  bit_cnt <= 4'h0;
               else if (samp)
                  bit_cnt <= bit_cnt + 4'h1;
               if (tick)
                  half <= half + 5'h01;
            end
            SPC_SLAVE_WAIT, SPC_SLAVE_SHIFT: begin
               if (!is_slave) begin
                  state   <= SPC_IDLE;
                  bit_cnt <= 4'h0;
               end else if (sel_reset || done) begin
                  state   <= SPC_SLAVE_WAIT;
                  bit_cnt <= 4'h0;
               end else if (samp) begin
                  state   <= SPC_SLAVE_SHIFT;
                  bit_cnt <= bit_cnt + 4'h1;
               end
               half <= 5'h00;
            end
            default: begin
               state   <= SPC_IDLE;
               bit_cnt <= 4'h0;
               half    <= 5'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Shifters
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_shift <= BUFFER_RESET;
         rx_shift <= BUFFER_RESET;
      end else begin
         if (accept)
            tx_shift <= wdata_in;
         else if (shift)
            tx_shift <= {tx_shift[6:0], 1'b0};
         if (samp)
            rx_shift <= rx_in;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sample_phase <= STATUS_RESET[ST_SAMPLE_PHASE];
         clock_edge   <= STATUS_RESET[ST_CLOCK_EDGE];
      end else if (wr_status) begin
         sample_phase <= wdata_in[ST_SAMPLE_PHASE];
         clock_edge   <= wdata_in[ST_CLOCK_EDGE];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_enable      <= CONTROL_RESET[CT_PORT_ENABLE];
         clock_polarity   <= CONTROL_RESET[CT_CLOCK_POLARITY];
         port_mode_select <= CONTROL_RESET[3:0];
      end else if (wr_control) begin
         port_enable      <= wdata_in[CT_PORT_ENABLE];
         clock_polarity   <= wdata_in[CT_CLOCK_POLARITY];
         port_mode_select <= wdata_in[3:0];
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         write_collision  <= CONTROL_RESET[CT_WRITE_COLLISION];
         receive_overflow <= CONTROL_RESET[CT_RECEIVE_OVERFLOW];
      end else begin
         if (wr_buffer && busy)
            write_collision <= 1'b1;
         else if (wr_control)
            write_collision <= wdata_in[CT_WRITE_COLLISION];
         if (done && is_slave && keep_full)
            receive_overflow <= 1'b1;
         else if (wr_control)
            receive_overflow <= wdata_in[CT_RECEIVE_OVERFLOW];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         transfer_buffer <= BUFFER_RESET;
         buffer_full     <= STATUS_RESET[ST_BUFFER_FULL];
      end else begin
         if (done && !(is_slave && keep_full)) begin
            transfer_buffer <= done_byte;
            buffer_full     <= 1'b1;
         end else begin
            if (accept)
               transfer_buffer <= wdata_in;
            if (rd_buffer)
               buffer_full <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_out <= 8'h00;
      end else if (read_in) begin
         unique case (addr_in)
            // Two-wire only bits and stop bit always read zero
            OFS_STATUS:  rdata_out <= {sample_phase, clock_edge, 5'h00,
                                       buffer_full};
            OFS_CONTROL: rdata_out <= {write_collision, receive_overflow,
                                       port_enable, clock_polarity,
                                       port_mode_select};
            OFS_BUFFER:  rdata_out <= transfer_buffer;
            default:     rdata_out <= 8'h00;
         endcase
      end else begin
         rdata_out <= 8'h00;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sck_out    <= 1'b0;
         sck_oe_out <= 1'b0;
         sdo_out    <= 1'b0;
         sdo_oe_out <= 1'b0;
         transfer_done_out <= 1'b0;
      end else begin
         if (state == SPC_MASTER_RUN && tick && half != HALF_LAST_LATE)
            sck_out <= !sck_out;
         else if (state != SPC_MASTER_RUN)
            sck_out <= clock_polarity;
         sck_oe_out <= spi_on && is_master;
         sdo_out    <= tx_shift[7];
         sdo_oe_out <= spi_on && !sel_reset;
         transfer_done_out <= done;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   AST_COLLISION_DROPS: assert property (
      wr_buffer && busy && !done |=> write_collision
      && transfer_buffer == $past(transfer_buffer))
      else $error("Write during transfer not dropped");
   AST_COLLISION_STICKS: assert property (
      write_collision && !wr_control |=> write_collision)
      else $error("Collision flag cleared by itself");
   AST_DONE_LOADS: assert property (
      done && !(is_slave && keep_full) |=> buffer_full
      && transfer_buffer == $past(done_byte) && transfer_done_out)
      else $error("Completed byte not loaded");
   AST_READ_CLEARS: assert property (
      rd_buffer && !done |=> !buffer_full)
      else $error("Buffer read left full flag set");
   AST_SLAVE_OVERRUN: assert property (
      done && is_slave && keep_full |=> receive_overflow
      && transfer_buffer == $past(transfer_buffer))
      else $error("Slave overrun not flagged");
   AST_MASTER_NO_OVF: assert property (
      is_master && !receive_overflow && !wr_control |=> !receive_overflow)
      else $error("Overflow set in master");
   AST_MASTER_START: assert property (
      accept && spi_on && is_master && state == SPC_IDLE
      |=> state == SPC_MASTER_RUN && tx_shift == $past(wdata_in))
      else $error("Master write did not start");
   AST_EIGHT_SAMPLES: assert property (
      done |-> bit_cnt == BITS_PER_WORD - 4'h1 && samp
      || state == SPC_MASTER_RUN && bit_cnt == BITS_PER_WORD)
      else $error("Transfer ended without eight bits");
   AST_MSB_FIRST: assert property (
      shift && !accept |=> tx_shift == {$past(tx_shift[6:0]), 1'b0})
      else $error("Shift not toward the top bit");
   AST_SELECT_RELEASE: assert property (
      spi_on && sel_reset |=> !sdo_oe_out && bit_cnt == 4'h0)
      else $error("Select high did not release");
   AST_DISABLE_IDLE: assert property (
      !port_enable |=> state == SPC_IDLE && !sck_oe_out && !sdo_oe_out)
      else $error("Disabled port still active");
   AST_CLOCK_IDLES: assert property (
      $fell(state == SPC_MASTER_RUN) && $stable(clock_polarity)
      |=> (sck_out == clock_polarity) [*2])
      else $error("Serial clock not back at idle");

   COV_MASTER_DONE: cover property (state == SPC_MASTER_RUN && done);
   COV_SLAVE_DONE: cover property (is_slave && done && !keep_full);
   COV_OVERRUN: cover property (is_slave && done && keep_full);
   COV_COLLISION: cover property (wr_buffer && busy);

endmodule // spc_core

// >>> rtl/spc_pkg.sv
/*
 * Shared constants, register map and types of the serial port core.
 * Assumes a single system clock; all users import the whole package.
 */
package spc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W      = 2;
   localparam int          DATA_W      = 8;
   localparam logic [1:0]  OFS_STATUS  = 2'h0;
   localparam logic [1:0]  OFS_CONTROL = 2'h1;
   localparam logic [1:0]  OFS_BUFFER  = 2'h2;

   localparam logic [7:0]  STATUS_RESET  = 8'h00;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [7:0]  BUFFER_RESET  = 8'h00;

   // Status fields
   localparam int ST_SAMPLE_PHASE = 7;
   localparam int ST_CLOCK_EDGE   = 6;
   localparam int ST_BUFFER_FULL  = 0;

   // Control fields
   localparam int CT_WRITE_COLLISION = 7;
   localparam int CT_RECEIVE_OVERFLOW = 6;
   localparam int CT_PORT_ENABLE     = 5;
   localparam int CT_CLOCK_POLARITY  = 4;

   // ----------------------------------------------------------------
   // Port modes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
   localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
   localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
   localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
   localparam logic [3:0] MODE_SLAVE_SELECT = 4'h4;
   localparam logic [3:0] MODE_SLAVE_FREE   = 4'h5;

   // ----------------------------------------------------------------
   // Timing counts (system clock cycles per serial clock half period, last half period index, bits per word)
   // ----------------------------------------------------------------
   localparam logic [5:0] HALF_DIV4  = 6'h02;
   localparam logic [5:0] HALF_DIV16 = 6'h08;
   localparam logic [5:0] HALF_DIV64 = 6'h20;
   localparam logic [4:0] HALF_LAST      = 5'h0F;
   localparam logic [4:0] HALF_LAST_LATE = 5'h10;
   localparam logic [3:0] BITS_PER_WORD  = 4'h8;

   typedef enum logic [1:0] {
      SPC_IDLE        = 2'b00,
      SPC_MASTER_RUN  = 2'b01,
      SPC_SLAVE_WAIT  = 2'b10,
      SPC_SLAVE_SHIFT = 2'b11
   } spc_state_e;

   function automatic logic spc_is_master(input logic [3:0] mode);
      return mode[3:2] == 2'b00;
   endfunction

   function automatic logic spc_is_slave(input logic [3:0] mode);
      return (mode == MODE_SLAVE_SELECT) || (mode == MODE_SLAVE_FREE);
   endfunction

endpackage

// >>> rtl/spc_rate_if.sv
/*
 * Link between the core and its serial clock rate generator.
 * Assumes both ends run on the same system clock.
 */
interface spc_rate_if;
   logic [1:0] rate_sel;     // Low bits of the master mode code
   logic       run;          // Master transfer in progress
   logic       timer_pulse;  // Timer two output pulse
   logic       tick;         // Half period elapsed

   modport gen  (input rate_sel, run, timer_pulse, output tick);
   modport core (output rate_sel, run, timer_pulse, input tick);
endinterface

// >>> rtl/spc_rate_gen.sv
/*
 * Serial clock rate generator: one tick per serial clock half period.
 * Assumes the timer pulse is a one-cycle pulse on the system clock.
 */
module spc_rate_gen (
   input  wire logic clock_in,    // System clock
   input  wire logic reset_n_in,  // Async reset, active low
   spc_rate_if.gen   rate_port    // Rate request and tick
);
   import spc_pkg::*;

   logic [5:0] count;
   logic [5:0] target;

   always_comb begin
      unique case (rate_port.rate_sel)
         2'b00:   target = HALF_DIV4;
         2'b01:   target = HALF_DIV16;
         default: target = HALF_DIV64;
      endcase
   end

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // Restarts from zero with every transfer, so in the divided modes the first
   // half period is full length; in timer mode it waits on the timer pulse.
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count          <= 6'h00;
         rate_port.tick <= 1'b0;
      end else if (!rate_port.run) begin
         count          <= 6'h00;
         rate_port.tick <= 1'b0;
      end else if (rate_port.rate_sel == 2'b11) begin
         count          <= 6'h00;
         rate_port.tick <= rate_port.timer_pulse;
      end else if (count == target - 6'h01) begin
         count          <= 6'h00;
         rate_port.tick <= 1'b1;
      end else begin
         count          <= count + 6'h01;
         rate_port.tick <= 1'b0;
      end
   end

endmodule // spc_rate_gen

// >>> verification/spc_peer_model.sv
/*
 * Far-side serial peripheral for the port bench, behavioural.
 * Assumes the clock idles low and data changes on its falling edge.
 */
module spc_peer_model (
   input  wire logic       sclk_in,   // Serial clock wire
   input  wire logic       mosi_in,   // Data from the core
   input  wire logic       load_in,   // Load reply, clear counts
   input  wire logic [7:0] tx_in,     // Reply byte
   output logic            miso_out,  // Data to the core
   output logic      [7:0] rx_out,    // Byte received
   output logic      [3:0] edges_out  // Rising edges seen
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] shift;
   assign miso_out = shift[7];
   always @(posedge sclk_in or posedge load_in) begin
      if (load_in) begin
         edges_out <= 4'h0;
      end else begin
         rx_out    <= {rx_out[6:0], mosi_in};
         edges_out <= edges_out + 4'h1;
      end
   end
   always @(negedge sclk_in or posedge load_in) begin
      if (load_in) shift <= tx_in;
      else shift <= {shift[6:0], 1'b0};
   end
endmodule // spc_peer_model

// >>> verification/tb_top.sv
/*
 * Self-checking bench: register access, master and slave transfers.
 * Assumes the core's pad wires are resolved here from its enables.
 */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import spc_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus and wires
   // ---------------------------------------------------------------
   logic       clock_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       write_in = 1'b0;
   logic       read_in = 1'b0;
   logic [1:0] addr_in = 2'h0;
   logic [7:0] wdata_in = 8'h00;
   logic [7:0] rdata_out, peer_rx;
   logic [3:0] edges;
   logic       sck_out, sck_oe_out, sdo_out, sdo_oe_out, done, miso;
   logic       tb_sck = 1'b0, tb_sdi = 1'b0, slave_on = 1'b0, load = 1'b0;
   logic       tb_sel_n = 1'b1;
   logic [2:0] tmr_cnt = 3'h0;
   wire        sck_w = sck_oe_out ? sck_out : tb_sck;
   int         error_cnt = 0;
   int         checked = 0;
   always #2 clock_in = ~clock_in;
   // Timer two stand-in: one pulse every eight system clocks
   always @(posedge clock_in) tmr_cnt <= tmr_cnt + 3'h1;
   spc_core dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
      .read_in(read_in), .rdata_out(rdata_out),
      .timer_two_in(tmr_cnt == 3'h7),
      .sck_in(sck_w), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
      .sdi_in(slave_on ? tb_sdi : miso), .sdo_out(sdo_out),
      .sdo_oe_out(sdo_oe_out), .select_n_in(tb_sel_n),
      .transfer_done_out(done));
   spc_peer_model peer_u (.sclk_in(sck_w), .mosi_in(sdo_out),
      .load_in(load), .tx_in(8'h3C), .miso_out(miso), .rx_out(peer_rx),
      .edges_out(edges));
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic end_sim;
      if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      addr_in <= a;
      wdata_in <= d;
      write_in <= 1'b1;
      @(posedge clock_in);
      write_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clock_in);
      read_in <= 1'b0;
      @(negedge clock_in);
      chk(rdata_out, exp);
      @(posedge clock_in);
   endtask
   task automatic wait_done;
      int n;
      for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge clock_in);
      if (n == 2000) begin
         error_cnt++;
         $display("[FAIL] %0t done %h exp %h", $time, done, 1'b1);
         end_sim();
      end
   endtask
   // Link clock of 64 ns, running only inside the frame; top nb bits
   task automatic sbyte(input logic [7:0] b, input int nb);
      for (int i = 7; i > 7 - nb; i--) begin
         tb_sdi <= b[i];
         repeat (8) @(posedge clock_in);
         tb_sck <= 1'b1;
         // Completion pulse follows the last leading edge, not the frame
         if (i == 0) wait_done();
         repeat (8) @(posedge clock_in);
         tb_sck <= 1'b0;
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic regs_at_reset;
      rd(OFS_STATUS, 8'h00);
      rd(OFS_CONTROL, 8'h00);
      rd(2'h3, 8'h00);
      wr(OFS_STATUS, 8'hFF);
      rd(OFS_STATUS, 8'hC0);
   endtask
   task automatic master_xfer;
      wr(OFS_CONTROL, 8'h21);
      wr(OFS_STATUS, 8'h40);
      load <= 1'b1;
      @(posedge clock_in);
      load <= 1'b0;
      chk({7'h00, sck_oe_out}, 8'h01);
      wr(OFS_BUFFER, 8'hA5);
      wr(OFS_BUFFER, 8'h11);
      wait_done();
      chk(peer_rx, 8'hA5);
      chk({4'h0, edges}, 8'h08);
      chk({7'h00, sck_out}, 8'h00);
      rd(OFS_STATUS, 8'h41);
      rd(OFS_CONTROL, 8'hA1);
      rd(OFS_BUFFER, 8'h3C);
      rd(OFS_STATUS, 8'h40);
      rd(OFS_CONTROL, 8'hA1);
   endtask
   task automatic timer_xfer;
      wr(OFS_CONTROL, 8'h23);
      wr(OFS_STATUS, 8'hC0);
      load <= 1'b1;
      @(posedge clock_in);
      load <= 1'b0;
      wr(OFS_BUFFER, 8'h69);
      wait_done();
      chk(peer_rx, 8'h69);
      chk({4'h0, edges}, 8'h08);
      rd(OFS_BUFFER, 8'h3C);
   endtask
   task automatic reset_mid;
      wr(OFS_CONTROL, 8'h22);
      wr(OFS_BUFFER, 8'hF0);
      repeat (40) @(posedge clock_in);
      chk({6'h00, sck_oe_out, sck_out}, 8'h03);
      reset_n_in <= 1'b0;
      @(posedge clock_in);
      chk({6'h00, sck_oe_out, sck_out}, 8'h00);
      reset_n_in <= 1'b1;
      @(posedge clock_in);
      rd(OFS_CONTROL, 8'h00);
   endtask
   task automatic slave_xfer;
      wr(OFS_CONTROL, 8'h25);
      wr(OFS_STATUS, 8'h40);
      slave_on <= 1'b1;
      chk({7'h00, sck_oe_out}, 8'h00);
      sbyte(8'h5A, 8);
      sbyte(8'hC3, 8);
      rd(OFS_CONTROL, 8'h65);
      rd(OFS_BUFFER, 8'h5A);
      rd(OFS_STATUS, 8'h40);
      wr(OFS_CONTROL, 8'h05);
      @(posedge clock_in);
      chk({6'h00, sdo_oe_out, sck_oe_out}, 8'h00);
   endtask
   task automatic select_xfer;
      wr(OFS_CONTROL, 8'h24);
      wr(OFS_BUFFER, 8'h81);
      @(posedge clock_in);
      chk({6'h00, sdo_oe_out, sdo_out}, 8'h01);
      tb_sel_n <= 1'b0;
      sbyte(8'hE0, 3);
      tb_sel_n <= 1'b1;
      repeat (4) @(posedge clock_in);
      chk({7'h00, sdo_oe_out}, 8'h00);
      tb_sel_n <= 1'b0;
      sbyte(8'h96, 8);
      rd(OFS_BUFFER, 8'h96);
   endtask
   initial begin
      repeat (10) @(posedge clock_in);
      reset_n_in <= 1'b1;
      @(posedge clock_in);
      regs_at_reset();
      master_xfer();
      timer_xfer();
      reset_mid();
      slave_xfer();
      select_xfer();
      end_sim();
   end
endmodule // tb_top
